/* ces_sequencer.sv */
/*
 Exception sequencer: takes exceptions at the execute stage, saves and
 updates the state word, obtains the vector, forms the vector address.
 Assumes the bus unit answers each request with done or transfer error.
*/
`timescale 1ns/1ps
module ces_sequencer
    import ces_pkg::*;
(
    input  wire logic            i_clk,
    input  wire logic            i_rst,
    input  wire logic            i_exec_valid,
    input  wire logic            i_exec_locked,
    input  wire logic            i_exec_done,
    input  wire logic            i_int_exc,
    input  wire logic [7:0]      i_int_vector,
    input  wire logic            i_access_err,
    input  wire logic            i_bpe,
    input  wire logic            i_push_err,
    input  wire logic            i_store_err,
    input  wire logic            i_rmw,
    input  wire logic            i_misaligned,
    input  wire logic            i_is_write,
    input  wire logic            i_is_instr,
    input  wire logic            i_mem_overlap,
    input  wire logic            i_tt_hit,
    input  wire logic            i_tt_super,
    input  wire logic            i_tt_wprot,
    input  wire logic [2:0]      i_interrupt_level_inputs,
    input  wire logic [15:0]     i_sw_write,
    input  wire logic            i_sw_we,
    input  wire logic [31:0]     i_vbr,
    input  wire logic            i_bus_done,
    input  wire logic            i_transfer_error_ack,
    input  wire logic [7:0]      i_bus_data,
    output logic                 o_abort_younger,
    output logic [15:0]          o_processor_state_word,
    output logic [15:0]          o_saved_state_word,
    output logic [FS_W-1:0]      o_fault_status_word,
    output logic                 o_bus_req,
    output logic [31:0]          o_bus_addr,
    output logic                 o_transfer_type_high,
    output logic                 o_transfer_type_low,
    output logic                 o_handler_valid,
    output logic                 o_int_pending
);
    typedef struct packed {
        ces_state_t       st;
        logic [15:0]      sw;
        logic [15:0]      saved;
        logic [FS_W-1:0]  fsw;
        logic [7:0]       vec;
        logic             is_int;
        logic [2:0]       lvl;
        logic             abort;
        logic             req;
        logic [31:0]      addr;
        logic [1:0]       tt;
        logic             hvalid;
        logic             pend;
    } ces_regs_t;

    ces_regs_t q_r;
    ces_regs_t q_nxt;
    logic [FS_W-1:0] fault_word;

    ces_fault_encode u_enc (
        .i_bpe         (i_bpe),
        .i_push_err    (i_push_err),
        .i_store_err   (i_store_err),
        .i_rmw         (i_rmw),
        .i_misaligned  (i_misaligned),
        .i_is_write    (i_is_write),
        .i_is_instr    (i_is_instr),
        .i_mem_overlap (i_mem_overlap),
        .i_tt_hit      (i_tt_hit),
        .i_tt_super    (i_tt_super),
        .i_tt_wprot    (i_tt_wprot),
        .o_word        (fault_word)
    );

    function automatic logic [31:0] vec_addr(input logic [31:0] base, input logic [7:0] v);
        vec_addr = base + {22'h0, v, 2'h0};
    endfunction

    always_comb begin
        q_nxt = q_r;
        q_nxt.abort = 1'b0;
        q_nxt.hvalid = 1'b0;
        q_nxt.pend = (i_interrupt_level_inputs > q_r.sw[SW_MASK_LSB+:3]);
        if (i_sw_we && q_r.st == CES_IDLE) begin
            q_nxt.sw = i_sw_write;
        end
        case (q_r.st)
            CES_IDLE: begin
                if (i_exec_valid && (i_access_err || i_int_exc)) begin
                    q_nxt.abort = 1'b1;
                    q_nxt.is_int = i_int_exc && !i_access_err;
                    q_nxt.lvl = i_interrupt_level_inputs;
                    if (i_access_err) begin
                        q_nxt.fsw = fault_word;
                    end
                    if (i_exec_locked && !i_access_err && !i_exec_done) begin
                        q_nxt.st = CES_DRAIN;
                    end else begin
                        q_nxt.st = CES_STATE;
                    end
                end
            end
            CES_DRAIN: begin
                if (i_exec_done || i_access_err) begin
                    q_nxt.st = CES_STATE;
                end
            end
            CES_STATE: begin
                q_nxt.saved = q_r.sw;
                q_nxt.sw[SW_S_BIT] = 1'b1;
                q_nxt.sw[SW_T_BIT] = 1'b0;
                if (q_r.is_int) begin
                    q_nxt.sw[SW_MASK_LSB+:3] = q_r.lvl;
                end
                q_nxt.st = CES_VEC;
            end
            CES_VEC: begin
                if (q_r.is_int) begin
                    q_nxt.req = 1'b1;
                    q_nxt.tt = TT_ACK;
                    q_nxt.addr = {29'h0, q_r.lvl};
                    q_nxt.st = CES_IACK;
                end else begin
                    q_nxt.vec = VEC_ACCESS;
                    q_nxt.req = 1'b1;
                    q_nxt.tt = TT_NORMAL;
                    q_nxt.addr = vec_addr(i_vbr, VEC_ACCESS);
                    q_nxt.st = CES_FETCH;
                end
            end
            CES_IACK: begin
                if (i_bus_done || i_transfer_error_ack) begin
                    // Error on acknowledge falls back to autovector
                    q_nxt.vec = i_transfer_error_ack
                        ? VEC_AUTO0 + {5'h0, q_r.lvl} : i_bus_data;
                    q_nxt.tt = TT_NORMAL;
                    q_nxt.addr = vec_addr(i_vbr, q_nxt.vec);
                    q_nxt.st = CES_FETCH;
                end
            end
            CES_FETCH: begin
                if (i_bus_done || i_transfer_error_ack) begin
                    q_nxt.req = 1'b0;
                    q_nxt.st = CES_DONE;
                end
            end
            CES_DONE: begin
                q_nxt.hvalid = 1'b1;
                q_nxt.st = CES_IDLE;
            end
            default: begin
                q_nxt.st = CES_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            q_r <= '0;
            q_r.st <= CES_IDLE;
            q_r.sw <= SW_RESET;
            q_r.vec <= VEC_RESET;
            q_r.addr <= RESET_VBR;
        end else begin
            q_r <= q_nxt;
        end
    end

    assign o_abort_younger = q_r.abort;
    assign o_processor_state_word = q_r.sw;
    assign o_saved_state_word = q_r.saved;
    assign o_fault_status_word = q_r.fsw;
    assign o_bus_req = q_r.req;
    assign o_bus_addr = q_r.addr;
    assign o_transfer_type_high = q_r.tt[1];
    assign o_transfer_type_low = q_r.tt[0];
    assign o_handler_valid = q_r.hvalid;
    assign o_int_pending = q_r.pend;

    super_set_a: assert property (@(posedge i_clk) disable iff (i_rst)
        q_r.st == CES_STATE |=> q_r.sw[SW_S_BIT] && !q_r.sw[SW_T_BIT]
            && q_r.saved == $past(q_r.sw))
        else $error("state word not updated");
    ack_type_a: assert property (@(posedge i_clk) disable iff (i_rst)
        q_r.st == CES_IACK |-> o_transfer_type_high && o_transfer_type_low)
        else $error("ack cycle type wrong");
    abort_pulse_a: assert property (@(posedge i_clk) disable iff (i_rst)
        q_r.st == CES_IDLE && i_exec_valid && i_access_err |=> o_abort_younger)
        else $error("younger not aborted");
    // Pending level
    // Both ways, so a stuck pending flag is caught too
    int_pend_a: assert property (@(posedge i_clk) disable iff (i_rst)
        o_int_pending == ($past(i_interrupt_level_inputs)
            > $past(q_r.sw[SW_MASK_LSB+:3])))
        else $error("pending flag disagrees with mask");
    locked_drain_a: assert property (@(posedge i_clk) disable iff (i_rst)
        q_r.st == CES_DRAIN && !i_exec_done && !i_access_err |=> q_r.st == CES_DRAIN)
        else $error("locked instruction cut");
    vec_fetch_a: assert property (@(posedge i_clk) disable iff (i_rst)
        q_r.st == CES_VEC && !q_r.is_int |=> o_bus_addr == i_vbr + 32'h8)
        else $error("bad vector address");
    fault_hold_a: assert property (@(posedge i_clk) disable iff (i_rst)
        q_r.st != CES_IDLE |=> $stable(o_fault_status_word))
        else $error("fault word changed");
    sequence vector_then_bus_s;
        q_r.st == CES_VEC ##1 q_r.st != CES_IDLE;
    endsequence
    step_order_a: assert property (@(posedge i_clk) disable iff (i_rst)
        q_r.st == CES_STATE |=> vector_then_bus_s)
        else $error("steps out of order");
endmodule // ces_sequencer

/* ces_pkg.sv */
/*
 Package of the exception sequencer: state word layout, fault word layout,
 vector numbers, transfer type codes and sequencer states.
 Assumes a single 25 MHz clock and a synchronous active-high reset.
*/
// What this block does
// - Exceptions are taken only at the execute stage; younger instructions are aborted.
// - Uninterruptible instructions finish first unless an access error stops them.
// - Each exception runs four steps; bus cycle order may differ.
// - Step one copies the state word, sets supervisor, clears trace.
// - Reset and interrupt also update the priority mask.
// - Interrupts get the vector from an acknowledge cycle; others internally.
// - Last step forms the vector address and fetches the handler.
// - Access errors taken from idle record full fault status, including branch mispredict.
// - Bus errors on push or store buffer writes set their fault flag.
// - Misaligned read-modify-write error reports direction 11, operand, misaligned.
// - Overlapping memory move destination fault reports direction 01.
// - Transparent translation faults set the translation window flag.
// - Translation faults set exactly one of four cause flags.
// - Restarted instruction re-issues the access; persistent errors fault again.
// - Only interrupt levels above the mask become pending.
// - Acknowledge cycle drives transfer type code 3.
package ces_pkg;
    localparam int SW_T_BIT      = 15;
    localparam int SW_S_BIT      = 13;
    localparam int SW_MASK_LSB   = 8;
    localparam logic [15:0] SW_RESET = 16'h2700;
    localparam logic [2:0]  MASK_ALL = 3'h7;

    localparam int FS_BPE   = 0;
    localparam int FS_PBE   = 1;
    localparam int FS_SBE   = 2;
    localparam int FS_MA    = 3;
    localparam int FS_IO    = 4;
    localparam int FS_RW_LSB = 5;
    localparam int FS_TTR   = 7;
    localparam int FS_SP    = 8;
    localparam int FS_WP    = 9;
    localparam int FS_RE    = 10;
    localparam int FS_WE    = 11;
    localparam int FS_W     = 12;

    localparam logic [1:0] RW_RMW   = 2'h3;
    localparam logic [1:0] RW_WRITE = 2'h1;
    localparam logic [1:0] RW_READ  = 2'h2;

    localparam logic [7:0] VEC_RESET  = 8'h00;
    localparam logic [7:0] VEC_ACCESS = 8'h02;
    localparam logic [7:0] VEC_AUTO0  = 8'h18;
    localparam logic [1:0] TT_NORMAL  = 2'h0;
    localparam logic [1:0] TT_ACK     = 2'h3;
    localparam logic [31:0] RESET_VBR = 32'h0000_0000;

    typedef enum logic [2:0] {
        CES_IDLE  = 3'h0,
        CES_DRAIN = 3'h1,
        CES_STATE = 3'h3,
        CES_VEC   = 3'h2,
        CES_IACK  = 3'h6,
        CES_FETCH = 3'h7,
        CES_DONE  = 3'h5
    } ces_state_t;
endpackage

/* ces_fault_encode.sv */
/*
 Combinational fault status encoder for access errors.
 Assumes at most one translation cause is signalled by the memory unit.
*/
`timescale 1ns/1ps
module ces_fault_encode
    import ces_pkg::*;
(
    input  wire logic            i_bpe,
    input  wire logic            i_push_err,
    input  wire logic            i_store_err,
    input  wire logic            i_rmw,
    input  wire logic            i_misaligned,
    input  wire logic            i_is_write,
    input  wire logic            i_is_instr,
    input  wire logic            i_mem_overlap,
    input  wire logic            i_tt_hit,
    input  wire logic            i_tt_super,
    input  wire logic            i_tt_wprot,
    output logic [FS_W-1:0]      o_word
);
    always_comb begin
        o_word = '0;
        o_word[FS_BPE] = i_bpe;
        o_word[FS_PBE] = i_push_err;
        o_word[FS_SBE] = i_store_err;
        o_word[FS_IO] = i_is_instr;
        o_word[FS_MA] = i_misaligned;
        if (i_rmw) begin
            o_word[FS_RW_LSB+:2] = RW_RMW;
        end else if (i_is_write || i_mem_overlap) begin
            o_word[FS_RW_LSB+:2] = RW_WRITE;
        end else begin
            o_word[FS_RW_LSB+:2] = RW_READ;
        end
        o_word[FS_TTR] = i_tt_hit;
        if (i_tt_hit) begin
            if (i_tt_super) begin
                o_word[FS_SP] = 1'b1;
            end else if (i_tt_wprot) begin
                o_word[FS_WP] = 1'b1;
            end else if (i_is_write) begin
                o_word[FS_WE] = 1'b1;
            end else begin
                o_word[FS_RE] = 1'b1;
            end
        end
    end
endmodule // ces_fault_encode

/* ces_bus_model.sv */
/*
 Bus partner model: answers sequencer requests after a set delay.
 Assumes the sequencer clock and its synchronous reset.
*/
`timescale 1ns/1ps
module ces_bus_model (
    input  wire logic        i_clk,
    input  wire logic        i_rst,
    input  wire logic        i_req,
    input  wire logic [31:0] i_addr,
    input  wire logic [1:0]  i_tt,
    input  wire logic [3:0]  i_delay,
    input  wire logic        i_ack_err,
    input  wire logic [7:0]  i_vector,
    output logic             o_done,
    output logic             o_err,
    output logic [7:0]       o_data
);
    logic [3:0]  cnt_r;
    logic        ans_r;
    logic [33:0] key_r;
    always_ff @(posedge i_clk) begin
        key_r <= {i_tt, i_addr};
        o_done <= 1'b0;
        o_err <= 1'b0;
        // Released data inverts each cycle so a stale vector matches only every second cycle
        o_data <= i_rst ? 8'hA5 : ~o_data;
        if (i_rst || !i_req || key_r != {i_tt, i_addr}) begin
            cnt_r <= 4'h0;
            ans_r <= 1'b0;
        end else if (!ans_r && cnt_r == i_delay) begin
            ans_r <= 1'b1;
            o_err <= i_ack_err && i_tt == 2'h3;
            o_done <= !(i_ack_err && i_tt == 2'h3);
            if (i_tt == 2'h3) o_data <= i_vector;
        end else if (!ans_r) begin
            cnt_r <= cnt_r + 4'h1;
        end
    end
endmodule // ces_bus_model

/* ces_sequencer_tb.sv */
/*
 Self-checking bench of the exception sequencer.
 Assumes the handed-over timing; inputs change at the falling edge.
*/
`timescale 1ns/1ps
module ces_sequencer_tb
    import ces_pkg::*;
;
    logic        clk, rst, ev, lk, ed, ie, ae, swe, done, transfer_error_ack, aerr;
    logic        abort, req, tth, ttl, hv, pend;
    logic [10:0] attr;
    logic [2:0]  lvl;
    logic [15:0] swd, sw, saved;
    logic [31:0] vbr, addr;
    logic [7:0]  bdata, vec;
    logic [11:0] fsw;
    logic [3:0]  dly;
    int          num_errors, comparisons;
    int          cycles = 0;

    ces_sequencer uut (
        .i_clk(clk), .i_rst(rst), .i_exec_valid(ev), .i_exec_locked(lk),
        .i_exec_done(ed), .i_int_exc(ie), .i_int_vector(8'h00), .i_access_err(ae),
        .i_bpe(attr[10]), .i_push_err(attr[9]), .i_store_err(attr[8]), .i_rmw(attr[7]),
        .i_misaligned(attr[6]), .i_is_write(attr[5]), .i_is_instr(attr[4]),
        .i_mem_overlap(attr[3]), .i_tt_hit(attr[2]), .i_tt_super(attr[1]),
        .i_tt_wprot(attr[0]), .i_interrupt_level_inputs(lvl), .i_sw_write(swd),
        .i_sw_we(swe), .i_vbr(vbr), .i_bus_done(done), .i_transfer_error_ack(transfer_error_ack),
        .i_bus_data(bdata), .o_abort_younger(abort), .o_processor_state_word(sw),
        .o_saved_state_word(saved), .o_fault_status_word(fsw), .o_bus_req(req),
        .o_bus_addr(addr), .o_transfer_type_high(tth), .o_transfer_type_low(ttl),
        .o_handler_valid(hv), .o_int_pending(pend));

    ces_bus_model bus (
        .i_clk(clk), .i_rst(rst), .i_req(req), .i_addr(addr), .i_tt({tth, ttl}),
        .i_delay(dly), .i_ack_err(aerr), .i_vector(vec), .o_done(done), .o_err(transfer_error_ack),
        .o_data(bdata));

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // Generous ceiling; a full run needs well under a thousand cycles
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            num_errors++;
            end_of_test();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic end_of_test();
        $display("errors=%0d comparisons=%0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    task automatic set_sw(input logic [15:0] d);
        @(negedge clk);
        {swe, swd} = {1'b1, d};
        @(negedge clk);
        swe = 1'b0;
        @(negedge clk);
        chk(32'(sw), 32'(d));
    endtask

    task automatic exc(input logic intr, input logic locked, input logic [10:0] a,
                       input logic [11:0] fm, input logic [11:0] fe);
        logic [31:0] fa;
        logic [7:0]  v;
        logic        ak;
        int          n;
        v = intr ? (aerr ? VEC_AUTO0 + {5'h0, lvl} : vec) : VEC_ACCESS;
        {fa, ak} = '0;
        set_sw(16'h8200);
        {ev, lk, ie, ae, attr} = {1'b1, locked, intr, !intr, a};
        @(negedge clk);
        {ev, ie, ae} = 3'h0;
        // Abort is a one-cycle pulse, so look right after the taking edge
        chk(32'(abort), 32'h1); // younger work aborted
        if (locked) begin
            repeat (5) @(negedge clk);
            chk(32'(sw), 32'h8200); // held while draining
            ed = 1'b1;
            @(negedge clk);
            {ed, lk} = 2'h0;
        end else begin
            @(negedge clk);
            chk(32'(abort), 32'h0); // abort lasts one cycle only
        end
        for (n = 0; n < 60 && hv !== 1'b1; n++) begin
            if (req === 1'b1 && {tth, ttl} === TT_ACK) ak = 1'b1;
            if (req === 1'b1 && {tth, ttl} === TT_NORMAL) fa = addr;
            @(negedge clk);
        end
        chk(32'(hv), 32'h1); // sequence completes
        chk(32'(ak), 32'(intr)); // ack cycle only for interrupts
        chk(fa, vbr + {22'h0, v, 2'h0}); // handler fetch address
        chk(32'(saved), 32'h8200); // state copy kept
        chk(32'(sw), intr ? {16'h0, 8'h20 | {5'h0, lvl}, 8'h00} : 32'h2200); // mode
        chk(32'(fsw & fm), 32'(fe)); // fault word latched
    endtask

    task automatic reset_test();
        chk(32'(sw), 32'(SW_RESET)); // reset sets full mask
        chk(32'(fsw), 32'h0); // no fault recorded yet
        chk(32'(req), 32'h0); // no bus cycle after reset
    endtask

    task automatic pend_test();
        set_sw(16'h8200);
        lvl = 3'h2;
        repeat (4) @(negedge clk);
        chk(32'(pend), 32'h0); // level at mask ignored
        lvl = 3'h3;
        repeat (4) @(negedge clk);
        chk(32'(pend), 32'h1); // level above mask pends
    endtask

    task automatic int_test();
        lvl = 3'h5;
        exc(1'b1, 1'b0, 11'h000, 12'h000, 12'h000); // prompt vector
        dly = 4'h3;
        exc(1'b1, 1'b1, 11'h000, 12'h000, 12'h000); // slow bus, locked
        aerr = 1'b1;
        exc(1'b1, 1'b0, 11'h000, 12'h000, 12'h000); // autovector on error
        {aerr, dly} = '0;
    endtask

    task automatic fault_test();
        exc(1'b0, 1'b0, 11'h0C0, 12'h078, 12'h068); // misaligned rmw
        exc(1'b0, 1'b0, 11'h0C0, 12'h078, 12'h068); // fault again on retry
        exc(1'b0, 1'b0, 11'h700, 12'h007, 12'h007); // buffer faults
        // Overlap alone, so the direction comes from the overlap input only
        exc(1'b0, 1'b0, 11'h008, 12'h060, 12'h020); // overlapping move
        exc(1'b0, 1'b0, 11'h006, 12'hF80, 12'h180); // supervisor
        exc(1'b0, 1'b0, 11'h005, 12'hF80, 12'h280); // write protect
        exc(1'b0, 1'b0, 11'h004, 12'hF80, 12'h480); // read error
        exc(1'b0, 1'b0, 11'h024, 12'hF80, 12'h880); // write error
    endtask

    initial begin
        {ev, lk, ed, ie, ae, swe, aerr, attr, swd, dly} = '0;
        {lvl, vbr, vec, rst} = {3'h5, 32'h0000_1000, 8'h40, 1'b1};
        repeat (4) @(negedge clk);
        rst = 1'b0;
        @(negedge clk);
        reset_test();
        pend_test();
        int_test();
        fault_test();
        end_of_test();
    end
endmodule // ces_sequencer_tb
